// File: rtl/lfs_cfg.svh
// Register offsets, field positions and reset values of the storage element library
`ifndef LFS_CFG_SVH
`define LFS_CFG_SVH

`define LFS_ADDR_W      12
`define LFS_ADDR_CTRL   12'h000
`define LFS_ADDR_DRIVE  12'h004
`define LFS_ADDR_STATUS 12'h008
`define LFS_ADDR_SR_LO  12'h00C
`define LFS_ADDR_SR_HI  12'h010
`define LFS_ADDR_SW_IN  12'h014

`define LFS_CTRL_SRC    0
`define LFS_CTRL_DIR_LO 1
`define LFS_CTRL_DIR_HI 4
`define LFS_CTRL_RST    5'h00
`define LFS_DRIVE_RST   28'h300_0000
`define LFS_SR_MAX      64
`define LFS_SR_MIN      4

`endif

// File: rtl/lfs_pkg.sv
// Types shared by the storage element library
package lfs_pkg;

	// Inputs of every element, from pins or from the drive register
	typedef struct packed {
		logic       nor_set;
		logic       nor_rst;
		logic       nand_set_n;
		logic       nand_rst_n;
		logic [1:0] dff_d;
		logic [1:0] dff_set;
		logic [1:0] dff_rst;
		logic [1:0] dff_clk;
		logic [1:0] jk_j;
		logic [1:0] jk_k;
		logic [1:0] jk_set;
		logic [1:0] jk_rst;
		logic [1:0] jk_clk;
		logic       sr_d;
		logic       sr_clk;
		logic [3:0] sw_ctrl;
	} lfs_in_s;

	// True and complement outputs of every latch and flip-flop; true output only of the shift chain
	typedef struct packed {
		logic       nor_q;
		logic       nor_qn;
		logic       nand_q;
		logic       nand_qn;
		logic [1:0] dff_q;
		logic [1:0] dff_qn;
		logic [1:0] jk_q;
		logic [1:0] jk_qn;
		logic       sr_q;
	} lfs_out_s;

	// Terminals of the four bilateral switches
	typedef struct packed {
		logic [3:0] a_out;
		logic [3:0] a_oe;
		logic [3:0] b_out;
		logic [3:0] b_oe;
	} lfs_sw_s;

	// Whole state of the block
	typedef struct packed {
		logic [4:0]  ctrl;
		lfs_in_s     drive;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
		logic        nor_q;
		logic        nand_q;
		logic [1:0]  dff_m;
		logic [1:0]  dff_q;
		logic [1:0]  dff_clk_p;
		logic [1:0]  jk_m;
		logic [1:0]  jk_q;
		logic [1:0]  jk_clk_p;
		logic        sr_clk_p;
		logic [63:0] sr;
		logic [3:0]  a_s1;
		logic [3:0]  a_s2;
		logic [3:0]  b_s1;
		logic [3:0]  b_s2;
		lfs_sw_s     sw;
	} lfs_state_s;

endpackage

// File: rtl/lfs_top.sv
// Latches, flip-flop pairs, static shift chain and bus switches behind an APB slave
`timescale 1ns/100ps
`include "lfs_cfg.svh"

// Behaviour
// - NOR latch holds complementary outputs while set and reset are low.
// - NOR latch set pulse makes true high, complement low, and it stays.
// - NOR latch reset pulse makes true low, complement high, and it stays.
// - Repeated pulses on one latch input change nothing; alternate to switch.
// - NAND latch uses active-low set and reset inputs that idle high.
// - D master follows data while clock low; slave holds, then loads the data input directly at the rising edge.
// - D flip-flop loads data on rising clock edge, complement is the inverse.
// - D flip-flop keeps its last captured value while no edges arrive.
// - D reset high forces true low; set high forces true high, any clock.
// - Two independent D flip-flops, each with own inputs and outputs.
// - J and K act as clocked set and reset, only at clock edges.
// - J-K toggle mode flips the output on every clock pulse.
// - J-K direct set and reset act at once on master and slave.
// - Two independent J-K flip-flops with own inputs and buffered outputs.
// - Shift chain stages feed each other, one common clock shifts them all.
// - Shift chain length is a parameter from four to sixty-four stages.
// - Four independent switches, each turned on or off by one control line.
// - Switch on passes high or low onto the line; off leaves it undriven.
module lfs_top
	import lfs_pkg::*;
#(
	parameter int SR_STAGES = 8
)(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`LFS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire lfs_in_s                elem_in,
	output lfs_out_s                    elem_out,
	input  wire logic [3:0]             sw_a_in,
	input  wire logic [3:0]             sw_b_in,
	output lfs_sw_s                     sw_pins
);

	localparam logic [63:0] SR_MASK = {64{1'b1}} >> (`LFS_SR_MAX - SR_STAGES);

	lfs_state_s s_q;
	lfs_state_s s_d;
	lfs_in_s    src;
	logic [1:0] dff_rise;
	logic [1:0] jk_rise;
	logic       sr_rise;
	logic       acc;
	logic       mapped;
	logic [31:0] rd_mux;

	// Element inputs come from same-clock logic or from software drive
	// Unused set/reset rely on outside tie-off
	assign src = s_q.ctrl[`LFS_CTRL_SRC] ? s_q.drive : elem_in;

	// Element clocks are levels; edges found against last cycle's level
	// Rising edge detect
	assign dff_rise = src.dff_clk & ~s_q.dff_clk_p;
	assign jk_rise  = src.jk_clk & ~s_q.jk_clk_p;
	assign sr_rise  = src.sr_clk & ~s_q.sr_clk_p;

	assign acc = psel & penable;

	// Address decode
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`LFS_ADDR_CTRL:   rd_mux = {27'h000_0000, s_q.ctrl};
			`LFS_ADDR_DRIVE:  rd_mux = {4'h0, s_q.drive};
			`LFS_ADDR_STATUS: rd_mux = {24'h00_0000, s_q.nor_q, s_q.nand_q, s_q.dff_q,
				s_q.jk_q, s_q.sr[SR_STAGES-1], 1'b0};
			`LFS_ADDR_SR_LO:  rd_mux = s_q.sr[31:0];
			`LFS_ADDR_SR_HI:  rd_mux = s_q.sr[63:32];
			`LFS_ADDR_SW_IN:  rd_mux = {24'h00_0000, s_q.b_s2, s_q.a_s2};
			default:          mapped = 1'b0;
		endcase
	end

	// Next state of every element and of the bus slave
	always_comb
	begin
		s_d = s_q;

		// One wait state: answer captured in the first access cycle
		if (acc && !s_q.ack)
		begin
			s_d.ack   = 1'b1;
			s_d.err   = ~mapped;
			s_d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
		end
		else if (acc && s_q.ack)
		begin
			s_d.ack = 1'b0;
			if (pwrite && mapped)
			begin
				if (paddr == `LFS_ADDR_CTRL)
					s_d.ctrl = pwdata[4:0];
				if (paddr == `LFS_ADDR_DRIVE)
					s_d.drive = pwdata[27:0];
			end
		end
		else
			s_d.ack = 1'b0;

		// Repeats on one input leave it unchanged
		if (src.nor_rst)
			// NOR reset, wins if both high
			s_d.nor_q = 1'b0;
		else if (src.nor_set)
			s_d.nor_q = 1'b1;

		if (!src.nand_rst_n)
			s_d.nand_q = 1'b0;
		else if (!src.nand_set_n)
			s_d.nand_q = 1'b1;

		for (int i = 0; i < 2; i++)
		begin
			if (!src.dff_clk[i])
				s_d.dff_m[i] = src.dff_d[i];
			if (dff_rise[i])
				s_d.dff_q[i] = src.dff_d[i];
			// Direct reset/set over clock and data
			if (src.dff_rst[i])
			begin
				s_d.dff_m[i] = 1'b0;
				s_d.dff_q[i] = 1'b0;
			end
			else if (src.dff_set[i])
			begin
				s_d.dff_m[i] = 1'b1;
				s_d.dff_q[i] = 1'b1;
			end

			if (!src.jk_clk[i])
				s_d.jk_m[i] = src.jk_j[i] | (~src.jk_k[i] & s_q.jk_q[i]);
			if (jk_rise[i])
			begin
				case ({src.jk_j[i], src.jk_k[i]})
					2'b10:   s_d.jk_q[i] = 1'b1;
					2'b01:   s_d.jk_q[i] = 1'b0;
					2'b11:   s_d.jk_q[i] = ~s_q.jk_q[i];
					default: s_d.jk_q[i] = s_q.jk_q[i];
				endcase
				s_d.jk_m[i] = s_d.jk_q[i];
			end
			// Direct set/reset on master and slave
			if (src.jk_rst[i])
			begin
				s_d.jk_m[i] = 1'b0;
				s_d.jk_q[i] = 1'b0;
			end
			else if (src.jk_set[i])
			begin
				s_d.jk_m[i] = 1'b1;
				s_d.jk_q[i] = 1'b1;
			end
		end
		s_d.dff_clk_p = src.dff_clk;
		s_d.jk_clk_p  = src.jk_clk;

		// Stages past the length stay clear
		if (sr_rise)
			s_d.sr = {s_q.sr[62:0], src.sr_d} & SR_MASK;
		s_d.sr_clk_p = src.sr_clk;

		// Pin levels pass two flops before the switch reads them
		s_d.a_s1 = sw_a_in;
		s_d.a_s2 = s_q.a_s1;
		s_d.b_s1 = sw_b_in;
		s_d.b_s2 = s_q.b_s1;

		// On drives the far side, off releases both
		for (int k = 0; k < 4; k++)
		begin
			s_d.sw.a_oe[k]  = src.sw_ctrl[k] & s_q.ctrl[`LFS_CTRL_DIR_LO + k];
			s_d.sw.b_oe[k]  = src.sw_ctrl[k] & ~s_q.ctrl[`LFS_CTRL_DIR_LO + k];
			s_d.sw.a_out[k] = s_d.sw.a_oe[k] & s_q.b_s2[k];
			s_d.sw.b_out[k] = s_d.sw.b_oe[k] & s_q.a_s2[k];
		end
	end

	// State register; NAND inputs reset to their idle-high level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q                  <= '0;
			s_q.ctrl             <= `LFS_CTRL_RST;
			s_q.drive            <= `LFS_DRIVE_RST;
		end
		else
			s_q <= s_d;
	end

	// Bus answer from flops; pready only inside an access
	assign pready  = acc & s_q.ack;
	assign pslverr = acc & s_q.ack & s_q.err;
	assign prdata  = s_q.rdata;

	// Complements are inverters on the state flops, so never equal
	assign elem_out.nor_q   = s_q.nor_q;
	assign elem_out.nor_qn  = ~s_q.nor_q;
	assign elem_out.nand_q  = s_q.nand_q;
	assign elem_out.nand_qn = ~s_q.nand_q;
	assign elem_out.dff_q   = s_q.dff_q;
	assign elem_out.dff_qn  = ~s_q.dff_q;
	assign elem_out.jk_q    = s_q.jk_q;
	assign elem_out.jk_qn   = ~s_q.jk_q;
	assign elem_out.sr_q    = s_q.sr[SR_STAGES-1];
	assign sw_pins          = s_q.sw;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_nor_hold: assert property (!src.nor_set && !src.nor_rst |=> $stable(s_q.nor_q))
		else $error("nor latch changed while idle");
	chk_nor_set: assert property (src.nor_set && !src.nor_rst |=> elem_out.nor_q && !elem_out.nor_qn)
		else $error("nor latch set failed");
	chk_nor_reset: assert property (src.nor_rst |=> !elem_out.nor_q && elem_out.nor_qn)
		else $error("nor latch reset failed");
	chk_nand_low: assert property (!src.nand_set_n && src.nand_rst_n |=> elem_out.nand_q)
		else $error("nand latch set failed");
	chk_dff_edge: assert property (dff_rise[0] && !src.dff_set[0] && !src.dff_rst[0]
		|=> elem_out.dff_q[0] == $past(src.dff_d[0]))
		else $error("d flop missed data at edge");
	chk_dff_static: assert property (!dff_rise[1] && !src.dff_set[1] && !src.dff_rst[1]
		|=> $stable(elem_out.dff_q[1]))
		else $error("d flop changed without edge");
	chk_dff_force: assert property (src.dff_rst[0] |=> !elem_out.dff_q[0])
		else $error("d flop reset ignored");
	chk_jk_toggle: assert property (jk_rise[0] && src.jk_j[0] && src.jk_k[0]
		&& !src.jk_set[0] && !src.jk_rst[0] |=> elem_out.jk_q[0] != $past(elem_out.jk_q[0]))
		else $error("jk toggle failed");
	chk_jk_noedge: assert property (!jk_rise[1] && !src.jk_set[1] && !src.jk_rst[1]
		|=> $stable(elem_out.jk_q[1]))
		else $error("jk moved without edge");
	chk_shift_move: assert property (sr_rise |=> s_q.sr[1] == $past(s_q.sr[0]))
		else $error("shift chain did not advance");
	chk_sw_off: assert property (!src.sw_ctrl[2] |=> !sw_pins.a_oe[2] && !sw_pins.b_oe[2])
		else $error("switch drives while off");
	chk_bus_ready: assert property (acc && !s_q.ack |=> pready || !acc)
		else $error("apb answer late");

	chk_nor_after: assert property (elem_out.nor_q && !src.nor_rst |=> elem_out.nor_q)
		else $error("nor latch lost set state");

	chk_nor_repeat: assert property (src.nor_set && !src.nor_rst && s_q.nor_q
		|=> $stable(s_q.nor_q))
		else $error("nor latch moved on repeated set");

	chk_nand_reset: assert property (!src.nand_rst_n
		|=> !elem_out.nand_q && elem_out.nand_qn)
		else $error("nand latch reset failed");

	// High idle inputs keep NAND latch
	chk_nand_hold: assert property (src.nand_set_n && src.nand_rst_n
		|=> $stable(s_q.nand_q))
		else $error("nand latch changed while idle");

	// Master follows data with clock low
	chk_dff_master: assert property (!src.dff_clk[0] && !src.dff_set[0] && !src.dff_rst[0]
		|=> s_q.dff_m[0] == $past(src.dff_d[0]))
		else $error("d master not transparent");

	chk_dff_mhold: assert property (src.dff_clk[1] && !src.dff_set[1] && !src.dff_rst[1]
		|=> $stable(s_q.dff_m[1]))
		else $error("d master moved with clock high");

	// First flop also static between edges
	chk_dff_hold0: assert property (!dff_rise[0] && !src.dff_set[0] && !src.dff_rst[0]
		|=> $stable(elem_out.dff_q[0]))
		else $error("d flop zero changed without edge");

	chk_dff_set: assert property (src.dff_set[1] && !src.dff_rst[1]
		|=> elem_out.dff_q[1] && !elem_out.dff_qn[1])
		else $error("d flop set ignored");

	chk_dff_rst1: assert property (src.dff_rst[1] |=> !elem_out.dff_q[1])
		else $error("d flop one reset ignored");

	// Second flop loads its own data
	chk_dff_pair: assert property (dff_rise[1] && !src.dff_set[1] && !src.dff_rst[1]
		|=> elem_out.dff_q[1] == $past(src.dff_d[1]))
		else $error("d flop one missed data at edge");

	// J alone sets at the edge
	chk_jk_set: assert property (jk_rise[1] && src.jk_j[1] && !src.jk_k[1]
		&& !src.jk_set[1] && !src.jk_rst[1] |=> elem_out.jk_q[1])
		else $error("jk clocked set failed");

	// K alone resets at the edge
	chk_jk_reset: assert property (jk_rise[0] && !src.jk_j[0] && src.jk_k[0]
		&& !src.jk_set[0] && !src.jk_rst[0] |=> !elem_out.jk_q[0])
		else $error("jk clocked reset failed");

	// Both low holds at the edge
	chk_jk_keep: assert property (jk_rise[0] && !src.jk_j[0] && !src.jk_k[0]
		&& !src.jk_set[0] && !src.jk_rst[0] |=> $stable(elem_out.jk_q[0]))
		else $error("jk hold failed");

	// Toggle on the second flop too
	chk_jk_toggle1: assert property (jk_rise[1] && src.jk_j[1] && src.jk_k[1]
		&& !src.jk_set[1] && !src.jk_rst[1]
		|=> elem_out.jk_q[1] != $past(elem_out.jk_q[1]))
		else $error("jk one toggle failed");

	// No move without a rising edge
	chk_jk_rise: assert property (!jk_rise[0] && !src.jk_set[0] && !src.jk_rst[0]
		|=> $stable(elem_out.jk_q[0]))
		else $error("jk zero moved without rising edge");

	chk_jk_direct: assert property (src.jk_rst[1]
		|=> !s_q.jk_q[1] && !s_q.jk_m[1])
		else $error("jk direct reset failed");

	chk_jk_dset: assert property (src.jk_set[0] && !src.jk_rst[0]
		|=> s_q.jk_q[0] && s_q.jk_m[0])
		else $error("jk direct set failed");

	chk_jk_pair: assert property (src.jk_set[1] && !src.jk_rst[1]
		|=> elem_out.jk_q[1] && !elem_out.jk_qn[1])
		else $error("jk one outputs wrong");

	// Stages past the length stay clear
	chk_shift_tail: assert property ((s_q.sr & ~SR_MASK) == 64'h0)
		else $error("shift chain beyond length");

	// An on switch drives one side only
	chk_sw_dir: assert property (src.sw_ctrl[1]
		|=> sw_pins.a_oe[1] != sw_pins.b_oe[1])
		else $error("switch side select wrong");

	// B side carries the synced A level
	chk_sw_pass_b: assert property (sw_pins.b_oe[3]
		|-> sw_pins.b_out[3] == $past(s_q.a_s2[3]))
		else $error("switch b level wrong");

	// A side carries the synced B level
	chk_sw_pass_a: assert property (sw_pins.a_oe[0]
		|-> sw_pins.a_out[0] == $past(s_q.b_s2[0]))
		else $error("switch a level wrong");

	// Completed control write lands
	chk_bus_write: assert property (pready && pwrite && paddr == `LFS_ADDR_CTRL
		|=> s_q.ctrl == $past(pwdata[4:0]))
		else $error("control write lost");

	cov_jk_toggle: cover property (jk_rise[1] && src.jk_j[1] && src.jk_k[1]);
	cov_shift_full: cover property (sr_rise && s_q.sr[SR_STAGES-1]);
	cov_sw_on: cover property (sw_pins.b_oe[0]);
	cov_bus_err: cover property (pslverr);

endmodule

// File: sim/lfs_far.sv
// Model of the surrounding logic: element inputs and far switch terminals
`timescale 1ns/100ps
module lfs_far
	import lfs_pkg::*;
(
	input  wire lfs_in_s    want,
	input  wire logic [3:0] lvl,
	input  wire lfs_sw_s    pins,
	output lfs_in_s         elem_in,
	output logic [3:0]      sw_a_in,
	output logic [3:0]      sw_b_in
);
	// never left floating
	// Every input is a driven level; unused set and reset stay inactive, low except the NAND pair, which idle high
	assign elem_in = want;
	// Wire level: the block wins while enabled, else our own terminal level
	assign sw_a_in = (pins.a_oe & pins.a_out) | (~pins.a_oe & lvl);
	assign sw_b_in = (pins.b_oe & pins.b_out) | (~pins.b_oe & ~lvl);
endmodule

// File: sim/tb_lfs_top.sv
// Self-checking bench for the storage element library
`timescale 1ns/100ps
`include "lfs_cfg.svh"
module tb_lfs_top;
	import lfs_pkg::*;
	localparam int STG = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, m, m2;
	logic [3:0]  lvl, sa, sb, dir;
	logic [63:0] sr;
	logic [1:0]  dq, jq, pd, pj;
	logic        nq, aq, ps;
	lfs_in_s     w, ei, v;
	lfs_out_s    eo;
	lfs_sw_s     sp;
	int          n_mismatch, n_tests, seed, i;

	lfs_top #(.SR_STAGES(STG)) lfs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .elem_in(ei),
		.elem_out(eo), .sw_a_in(sa), .sw_b_in(sb), .sw_pins(sp));
	lfs_far lfs_far_i (.want(w), .lvl(lvl), .pins(sp), .elem_in(ei), .sw_a_in(sa),
		.sw_b_in(sb));

	// Bench clock, 5 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
		begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// One input sample; the model advances alike, then outputs are compared
	task automatic go(input lfs_in_s x);
		int j;
		@(posedge pclk);
		w <= x;
		nq = x.nor_rst ? 1'b0 : (x.nor_set | nq);
		aq = !x.nand_rst_n ? 1'b0 : (!x.nand_set_n | aq);
		for (j = 0; j < 2; j++)
		begin
			dq[j] = x.dff_rst[j] ? 1'b0 : x.dff_set[j] ? 1'b1
				: (x.dff_clk[j] & !pd[j]) ? x.dff_d[j] : dq[j];
			jq[j] = x.jk_rst[j] ? 1'b0 : x.jk_set[j] ? 1'b1 : !(x.jk_clk[j] & !pj[j]) ? jq[j]
				: (x.jk_j[j] & !jq[j]) | (!x.jk_k[j] & jq[j]);
		end
		pd = x.dff_clk;
		pj = x.jk_clk;
		if (x.sr_clk & !ps)
			sr = {sr[62:0], x.sr_d} & ((64'h1 << STG) - 64'h1);
		ps = x.sr_clk;
		@(posedge pclk);
		#1;
		chk(eo, {nq, !nq, aq, !aq, dq, ~dq, jq, ~jq, sr[STG-1]});
		chk({sp.a_oe, sp.b_oe}, {x.sw_ctrl & dir, x.sw_ctrl & ~dir});
	endtask

	initial
	begin
		seed = 32'h68f3;
		n_mismatch = 0;
		n_tests = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
		{nq, aq, dq, jq, pd, pj, ps, sr, dir} = '0;
		w = '0;
		w.nand_set_n = 1'b1;
		w.nand_rst_n = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `LFS_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `LFS_ADDR_DRIVE, 32'h0);
		chk(rd, `LFS_DRIVE_RST);
		// Random inputs; set and reset kept rare so clocked behaviour shows
		for (i = 0; i < 600; i++)
		begin
			m = $random(seed);
			m2 = $random(seed);
			v = lfs_in_s'(m[27:0]);
			m = $random(seed);
			v.nor_set &= m[8];
			v.nor_rst &= m[9] & m2[9];
			v.nand_set_n |= m[10];
			v.nand_rst_n |= m[11] | m2[11];
			v.dff_set &= m[1:0] & m2[1:0];
			v.dff_rst &= m[3:2] & m2[3:2];
			v.jk_set &= m[5:4] & m2[5:4];
			v.jk_rst &= m[7:6] & m2[7:6];
			go(v);
			if (i % 100 == 99)
			begin
				apb(1'b0, `LFS_ADDR_STATUS, 32'h0);
				chk(rd, {nq, aq, dq, jq, sr[STG-1], 1'b0});
				apb(1'b0, `LFS_ADDR_SR_LO, 32'h0);
				chk(rd, sr[31:0]);
			end
		end
		// Switches pass A to B, then B to A after the direction write
		v.sw_ctrl = 4'hF;
		lvl = 4'hA;
		go(v);
		repeat (4) @(posedge pclk);
		#1;
		chk(sp, {4'h0, 4'h0, 4'hA, 4'hF});
		apb(1'b1, `LFS_ADDR_CTRL, 32'h1E);
		dir = 4'hF;
		repeat (4) @(posedge pclk);
		#1;
		chk({sp.a_out, sp.a_oe, sp.b_oe}, {4'h5, 4'hF, 4'h0});
		v.sw_ctrl = 4'h0;
		go(v);
		apb(1'b1, `LFS_ADDR_DRIVE, 32'hFABC_1234);
		apb(1'b0, `LFS_ADDR_DRIVE, 32'h0);
		chk(rd, 32'h0ABC_1234);
		apb(1'b0, 12'h018, 32'h0);
		chk({e, rd}, 33'h1_0000_0000);
		give_verdict();
	end
endmodule
